// File: rtl/agse_gpe_status_enable.sv
`timescale 1ns/1ns
// Summary of operation
// - Keyboard wake flag sets on keyboard IRQ when its wake enable and module active
// - Writing one clears a status flag; writing zero leaves it alone
// - Port-line flag sets while the aux output pin is high and module active
// - Alarm wake flag sets on any alarm event and mirrors the PM alarm bit
// - Writing one to the alarm flag clears it and the mirrored alarm bit
// - Keyboard and port-line flags read zero after reset until an event
// - Low byte of the event enable map lives at offset 04h
// - Enable bit n lets pin n events of port 1 raise the PM interrupt
// - Enable bits are read/write and reset to zero
// - Mouse wake flag sets on mouse IRQ when its wake enable and module active
module agse_gpe_status_enable
	import agse_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [AGSE_ADDR_W-1:0] paddr,
	input  wire logic [AGSE_DATA_W-1:0] pwdata,
	input  wire logic [3:0]             pstrb,
	output      logic [AGSE_DATA_W-1:0] prdata,
	output      logic                   pready,
	output      logic                   pslverr,
	// Keyboard and mouse controller
	input  wire logic                   kbd_irq,
	input  wire logic                   ms_irq,
	input  wire logic                   kbd_wake_enable,
	input  wire logic                   ms_wake_enable,
	input  wire logic                   kbc_module_active,
	input  wire logic                   kbc_aux_output_pin,
	// Real-time clock alarm and PM status high register
	input  wire logic                   rtc_alarm_event,
	input  wire logic                   pm_alarm_status_clear,
	output      logic                   pm_alarm_status_bit,
	// Event capable GPIO port 1
	input  wire logic [AGSE_PIN_W-1:0]  gpio_port1_event,
	// Power management interrupt
	output      logic                   pm_interrupt_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	// All event sources come from pins or other domains, so every one is
	// double registered; only the second stage feeds any logic.
	logic [AGSE_SYNC_W-1:0] sync1_r;
	logic [AGSE_SYNC_W-1:0] sync2_r;
	logic [AGSE_SYNC_W-1:0] sync_in;

	always_comb begin
		sync_in = {gpio_port1_event,
			rtc_alarm_event,
			kbc_aux_output_pin,
			kbc_module_active,
			ms_wake_enable,
			kbd_wake_enable,
			ms_irq,
			kbd_irq};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= AGSE_RST_SYNC;
			sync2_r <= AGSE_RST_SYNC;
		end else begin
			sync1_r <= sync_in;
			sync2_r <= sync1_r;
		end
	end

	logic                  s_kbd_irq;
	logic                  s_ms_irq;
	logic                  s_kbd_wen;
	logic                  s_ms_wen;
	logic                  s_active;
	logic                  s_aux;
	logic                  s_alarm;
	logic [AGSE_PIN_W-1:0] s_pins;

	always_comb begin
		s_kbd_irq = sync2_r[AGSE_SYNC_KBD_IRQ];
		s_ms_irq  = sync2_r[AGSE_SYNC_MS_IRQ];
		s_kbd_wen = sync2_r[AGSE_SYNC_KBD_WEN];
		s_ms_wen  = sync2_r[AGSE_SYNC_MS_WEN];
		s_active  = sync2_r[AGSE_SYNC_ACTIVE];
		s_aux     = sync2_r[AGSE_SYNC_AUX];
		s_alarm   = sync2_r[AGSE_SYNC_ALARM];
		s_pins    = sync2_r[AGSE_SYNC_PIN_LSB +: AGSE_PIN_W];
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	logic setup_ph;
	logic access_ph;
	logic hit_evt;
	logic hit_gpio;
	logic hit_flag;
	logic hit_pin;
	logic mapped;
	logic wr_en;
	logic rd_done;

	always_comb begin
		hit_evt  = 1'b0;
		hit_gpio = 1'b0;
		hit_flag = 1'b0;
		hit_pin  = 1'b0;
		if (paddr == AGSE_OFS_EVT_STS) begin
			hit_evt = 1'b1;
		end else if (paddr == AGSE_OFS_GPIO_EN) begin
			hit_gpio = 1'b1;
		end else if (paddr == AGSE_OFS_FLAG_EN) begin
			hit_flag = 1'b1;
		end else if (paddr == AGSE_OFS_PIN_STS) begin
			hit_pin = 1'b1;
		end
		mapped    = hit_evt | hit_gpio | hit_flag | hit_pin;
	end

	// Every register fits in the low byte lane, so lanes 1 to 3 carry nothing
	always_comb begin
		setup_ph  = psel & ~penable;
		access_ph = psel & penable;
		// Unmapped or byte-lane-less writes store nothing
		wr_en     = access_ph & pwrite & mapped & pstrb[0];
		rd_done   = access_ph & ~pwrite;
	end

	// Read data is captured in setup, so the access phase always completes at once
	// With no wait states there is no timeout path; pslverr marks unmapped offsets only
	always_comb begin
		pready  = 1'b1;
		pslverr = access_ph & ~mapped;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event status flags
	// Bits follow the status register: alarm, port line, keyboard, mouse
	logic [AGSE_FLAG_W-1:0] flags_r;
	logic [AGSE_FLAG_W-1:0] flags_nxt;
	logic [AGSE_FLAG_W-1:0] flag_set;
	logic [AGSE_FLAG_W-1:0] flag_clr;

	always_comb begin
		flag_set = '0;
		flag_set[AGSE_BIT_KBD_IRQ]   = s_kbd_irq & s_kbd_wen & s_active;
		flag_set[AGSE_BIT_MS_IRQ]    = s_ms_irq & s_ms_wen & s_active;
		flag_set[AGSE_BIT_PORT_LINE] = s_aux & s_active;
		flag_set[AGSE_BIT_ALARM]     = s_alarm;
		flag_clr = '0;
		if (wr_en && hit_evt) begin
			flag_clr = pwdata[AGSE_FLAG_W-1:0];
		end
		// Clearing the mirrored PM alarm bit clears this flag too
		if (pm_alarm_status_clear) begin
			flag_clr[AGSE_BIT_ALARM] = 1'b1;
		end
		// A new event in the clearing cycle survives the clear; sources are levels,
		// so a flag cannot be cleared while its source still holds it set
		flags_nxt = (flags_r & ~flag_clr) | flag_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= AGSE_RST_FLAGS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// One storage bit backs both views, so the two can never disagree
	always_comb begin
		pm_alarm_status_bit = flags_r[AGSE_BIT_ALARM];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enable registers
	// Enables only gate the line; status keeps latching while its enable is clear
	logic [AGSE_PIN_W-1:0]  gpio_en_r;
	logic [AGSE_PIN_W-1:0]  gpio_en_nxt;
	logic [AGSE_FLAG_W-1:0] flag_en_r;
	logic [AGSE_FLAG_W-1:0] flag_en_nxt;

	always_comb begin
		gpio_en_nxt = gpio_en_r;
		flag_en_nxt = flag_en_r;
		if (wr_en && hit_gpio) begin
			gpio_en_nxt = pwdata[AGSE_PIN_W-1:0];
		end
		if (wr_en && hit_flag) begin
			flag_en_nxt = pwdata[AGSE_FLAG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio_en_r <= AGSE_RST_GPIO_EN;
			flag_en_r <= AGSE_RST_FLAG_EN;
		end else begin
			gpio_en_r <= gpio_en_nxt;
			flag_en_r <= flag_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin event status, sticky, cleared by reading
	logic [AGSE_PIN_W-1:0] pin_sts_r;
	logic [AGSE_PIN_W-1:0] pin_sts_nxt;
	logic [AGSE_PIN_W-1:0] pin_clr;

	always_comb begin
		pin_clr = '0;
		// Only bits software actually saw in setup are cleared, so an event
		// landing between setup and access is kept for the next read
		if (rd_done && hit_pin) begin
			pin_clr = prdata[AGSE_PIN_W-1:0];
		end
		pin_sts_nxt = (pin_sts_r & ~pin_clr) | s_pins;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sts_r <= AGSE_RST_PIN_STS;
		end else begin
			pin_sts_r <= pin_sts_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data
	logic [AGSE_DATA_W-1:0] rdata_r;
	logic [AGSE_DATA_W-1:0] rdata_nxt;
	logic [AGSE_DATA_W-1:0] rd_mux;

	// Unmapped offsets fall through to zero, which is what the bus reads back
	always_comb begin
		rd_mux = '0;
		if (hit_evt) begin
			rd_mux[AGSE_FLAG_W-1:0] = flags_r;
		end else if (hit_gpio) begin
			rd_mux[AGSE_PIN_W-1:0] = gpio_en_r;
		end else if (hit_flag) begin
			rd_mux[AGSE_FLAG_W-1:0] = flag_en_r;
		end else if (hit_pin) begin
			rd_mux[AGSE_PIN_W-1:0] = pin_sts_r;
		end
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (setup_ph && !pwrite) begin
			rdata_nxt = rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= AGSE_RST_RDATA;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_comb begin
		prdata = rdata_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power management interrupt
	// Level output from its own register, fed from next-state terms so it adds no delay
	logic                   pm_int_r;
	logic                   pm_int_nxt;
	logic [AGSE_PIN_W-1:0]  pin_pend;
	logic [AGSE_FLAG_W-1:0] flag_pend;

	// Next-state terms keep the line in step with the status bits, so software
	// never finds a pending bit while the line is still low
	always_comb begin
		pin_pend   = pin_sts_nxt & gpio_en_nxt;
		flag_pend  = flags_nxt & flag_en_nxt;
		pm_int_nxt = (|pin_pend) | (|flag_pend);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_int_r <= AGSE_RST_INT;
		end else begin
			pm_int_r <= pm_int_nxt;
		end
	end

	always_comb begin
		pm_interrupt_out = pm_int_r;
	end

endmodule : agse_gpe_status_enable

// File: rtl/agse_pkg.sv
package agse_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int          AGSE_ADDR_W        = 12;
	localparam int          AGSE_DATA_W        = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [11:0] AGSE_OFS_EVT_STS   = 12'h000;
	localparam logic [11:0] AGSE_OFS_GPIO_EN   = 12'h004;
	localparam logic [11:0] AGSE_OFS_FLAG_EN   = 12'h008;
	localparam logic [11:0] AGSE_OFS_PIN_STS   = 12'h00C;

	////////////////////////////////////////////////////////////////////////////////
	// Event status flag positions
	localparam int          AGSE_FLAG_W        = 4;
	localparam int          AGSE_BIT_ALARM     = 0;
	localparam int          AGSE_BIT_PORT_LINE = 1;
	localparam int          AGSE_BIT_KBD_IRQ   = 2;
	localparam int          AGSE_BIT_MS_IRQ    = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Pin event port and enable byte
	localparam int          AGSE_PIN_W         = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised input vector layout
	localparam int          AGSE_SYNC_KBD_IRQ  = 0;
	localparam int          AGSE_SYNC_MS_IRQ   = 1;
	localparam int          AGSE_SYNC_KBD_WEN  = 2;
	localparam int          AGSE_SYNC_MS_WEN   = 3;
	localparam int          AGSE_SYNC_ACTIVE   = 4;
	localparam int          AGSE_SYNC_AUX      = 5;
	localparam int          AGSE_SYNC_ALARM    = 6;
	localparam int          AGSE_SYNC_PIN_LSB  = 7;
	localparam int          AGSE_SYNC_W        = 15;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [3:0]  AGSE_RST_FLAGS     = 4'h0;
	localparam logic [3:0]  AGSE_RST_FLAG_EN   = 4'h0;
	localparam logic [7:0]  AGSE_RST_GPIO_EN   = 8'h00;
	localparam logic [7:0]  AGSE_RST_PIN_STS   = 8'h00;
	localparam logic [14:0] AGSE_RST_SYNC      = 15'h0000;
	localparam logic [31:0] AGSE_RST_RDATA     = 32'h0000_0000;
	localparam logic        AGSE_RST_INT       = 1'h0;

endpackage : agse_pkg

// File: verif/agse_gpe_status_enable_checker.sv
`timescale 1ns/1ns
module agse_gpe_status_enable_checker
	import agse_pkg::*;
(
	// Clock, reset and bus
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [AGSE_ADDR_W-1:0] paddr,
	input wire logic [AGSE_DATA_W-1:0] pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic [AGSE_DATA_W-1:0] prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Event sources and outputs
	input wire logic                   kbd_irq,
	input wire logic                   ms_irq,
	input wire logic                   kbc_aux_output_pin,
	input wire logic                   rtc_alarm_event,
	input wire logic                   pm_alarm_status_clear,
	input wire logic                   pm_alarm_status_bit,
	input wire logic [AGSE_PIN_W-1:0]  gpio_port1_event,
	input wire logic                   pm_interrupt_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Raw sources only; enables alone can never set a flag
	wire logic ev = kbd_irq | ms_irq | kbc_aux_output_pin | rtc_alarm_event | (|gpio_port1_event);
	wire logic map = paddr inside {AGSE_OFS_EVT_STS, AGSE_OFS_GPIO_EN, AGSE_OFS_FLAG_EN,
		AGSE_OFS_PIN_STS};
	wire logic stw = psel && penable && pwrite && paddr == AGSE_OFS_EVT_STS && pstrb[0];

	AST_PREADY: assert property (pready) else $error("pready low");
	AST_SLVERR: assert property (pslverr == (psel && penable && !map))
		else $error("pslverr wrong");
	AST_UNMAP_RD: assert property (psel && !penable && !pwrite && !map |=> prdata == 32'h0)
		else $error("unmapped read data");
	AST_ALARM_SET: assert property (rtc_alarm_event |-> ##3 pm_alarm_status_bit)
		else $error("alarm flag not set");
	AST_ALARM_HOLD: assert property (pm_alarm_status_bit && !pm_alarm_status_clear &&
		!(stw && pwdata[0]) |=> pm_alarm_status_bit) else $error("alarm flag lost");
	AST_ALARM_W1C: assert property ((stw && pwdata[0] || pm_alarm_status_clear) &&
		!rtc_alarm_event && !$past(rtc_alarm_event) && !$past(rtc_alarm_event, 2)
		|=> !pm_alarm_status_bit) else $error("alarm flag not cleared");
	AST_RESET_ZERO: assert property ($rose(presetn) |-> !pm_interrupt_out &&
		!pm_alarm_status_bit && prdata == 32'h0) else $error("outputs not reset");
	AST_IRQ_QUIET: assert property (!psel && !ev && !$past(ev) && !$past(ev, 2)
		|=> !$rose(pm_interrupt_out)) else $error("interrupt without cause");

	COV_W1C: cover property (stw && pwdata[0] && pm_alarm_status_bit);
	COV_IRQ: cover property ($rose(pm_interrupt_out));
	COV_ERR: cover property (pslverr);
endmodule : agse_gpe_status_enable_checker

bind agse_gpe_status_enable agse_gpe_status_enable_checker u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .kbd_irq, .ms_irq,
	.kbc_aux_output_pin, .rtc_alarm_event, .pm_alarm_status_clear, .pm_alarm_status_bit,
	.gpio_port1_event, .pm_interrupt_out);

// File: verif/agse_sci_rx.sv
`timescale 1ns/1ns
module agse_sci_rx (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Interrupt line and requests seen
	input  wire logic       pm_interrupt_out,
	output      logic [7:0] rise_cnt
);
	logic prev_r;
	// Level line: one request per assertion, however long it stays high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r   <= 1'b0;
			rise_cnt <= 8'h00;
		end else begin
			prev_r   <= pm_interrupt_out;
			rise_cnt <= rise_cnt + {7'h00, pm_interrupt_out & ~prev_r};
		end
	end
endmodule : agse_sci_rx

// File: verif/agse_gpe_status_enable_test.sv
`timescale 1ns/1ns
module agse_gpe_status_enable_test;
	import agse_pkg::*;
	typedef struct packed {logic w; logic [14:0] ev; logic [11:0] a; logic [31:0] d, x;} agse_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, abit, aclr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [14:0] evs;
	logic [3:0]  strb = 4'hF;
	logic [7:0]  rises;
	int          error_cnt, check_count, i;
	// Event bits: kbd, ms, kbd wake en, ms wake en, active, aux, alarm, pins 7..0
	agse_row_t rows [11] = '{
		'{1'b0, 15'h5400, 12'h000, 32'h0, 32'h4},
		'{1'b0, 15'h4400, 12'h000, 32'h0, 32'h0},
		'{1'b0, 15'h5000, 12'h000, 32'h0, 32'h0},
		'{1'b0, 15'h2C00, 12'h000, 32'h0, 32'h8},
		'{1'b0, 15'h0600, 12'h000, 32'h0, 32'h2},
		'{1'b0, 15'h0200, 12'h000, 32'h0, 32'h0},
		'{1'b0, 15'h0100, 12'h000, 32'h0, 32'h1},
		'{1'b0, 15'h0081, 12'h00C, 32'h0, 32'h81},
		'{1'b1, 15'h0000, 12'h004, 32'hA5, 32'hA5},
		'{1'b1, 15'h0000, 12'h004, 32'hFFFFFFFF, 32'hFF},
		'{1'b1, 15'h0000, 12'h008, 32'hFFFFFFFF, 32'hF}};

	agse_gpe_status_enable uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .kbd_irq(evs[14]), .ms_irq(evs[13]),
		.kbd_wake_enable(evs[12]), .ms_wake_enable(evs[11]), .kbc_module_active(evs[10]),
		.kbc_aux_output_pin(evs[9]), .rtc_alarm_event(evs[8]), .pm_alarm_status_clear(aclr),
		.pm_alarm_status_bit(abit), .gpio_port1_event(evs[7:0]), .pm_interrupt_out(irq));
	agse_sci_rx u_rx (.pclk(pclk), .presetn(presetn), .pm_interrupt_out(irq), .rise_cnt(rises));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Wait states are the slave's choice; only the watchdog ends a hung access
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic drive(input logic [14:0] v);
		evs <= v;
		repeat (4) @(posedge pclk);
		evs <= 15'h0000;
		repeat (4) @(posedge pclk);
	endtask : drive

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		#300000;
		error_cnt++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		complete_run();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, evs, aclr} = '0;
		do_reset();
		for (i = 0; i < 11; i++) begin
			drive(rows[i].ev);
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].x);
			apb(1'b1, 12'h000, 32'hF);
			apb(1'b0, 12'h00C, 32'h0);
			$display("row %0d done", i);
		end
		do_reset();
		for (i = 0; i < 16; i += 4) begin
			apb(1'b0, i[11:0], 32'h0);
			chk(rd, 32'h0);
		end
		chk({irq, abit}, 32'h0);
		$display("reset test done");
		drive(15'h5500);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, 12'h000, 32'h4);
		apb(1'b0, 12'h000, 32'h0);
		chk({rd[3:0], abit}, 32'h3);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk({rd[3:0], abit}, 32'h0);
		$display("clear test done");
		apb(1'b1, 12'h004, 32'h8);
		drive(15'h0010);
		chk(irq, 32'h0);
		drive(15'h0008);
		chk(irq, 32'h1);
		apb(1'b0, 12'h00C, 32'h0);
		@(posedge pclk);
		chk(rd, 32'h18);
		chk(irq, 32'h0);
		apb(1'b1, 12'h008, 32'h1);
		drive(15'h0100);
		chk(irq, 32'h1);
		aclr <= 1'b1;
		@(posedge pclk);
		aclr <= 1'b0;
		@(posedge pclk);
		chk({irq, abit}, 32'h0);
		$display("interrupt test done");
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		chk(se, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk(se, 32'h1);
		chk(rd, 32'h0);
		strb <= 4'hE;
		apb(1'b1, 12'h004, 32'h5A);
		strb <= 4'hF;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h8);
		chk(rises, 32'h2);
		$display("unmapped test done");
		complete_run();
	end
endmodule : agse_gpe_status_enable_test
